// ### core/tcp_pwm.sv
// Three-channel PWM generator with Avalon-MM register slave
// Notes on behaviour
// [R1] Output-enable bit runs its channel and routes waveform to its pin.
// [R2] Channel 1 drives pin P1.3, channel 2 drives pin P1.6.
// [R3] Clear bit forces channel cleared and held; all clear bits reset 0.
// [R4] Channel interrupt enable counts only with the shared master enable set.
// [R5] Select 00/01 system clock, 10 RC clock, 11 twice RC clock.
// [R6] Select fields at 5:4, 3:2, 1:0; each resets to code 10.
// [R7] Held channel: counter zero, output inactive, restarts from zero.
module tcp_pwm #(
  parameter int NCH = 3
) (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Internal RC clock and its doubled form, from another domain
  input wire logic rc_clk_pin,
  input wire logic rc2_clk_pin,
  // Avalon-MM slave
  input wire tcp_pkg::tcp_av_req_t av_req,
  output logic [31:0] av_readdata,
  output logic av_waitrequest,
  // Pins: P1.2, P1.3, P1.6 outputs with active-low enable
  output logic [NCH-1:0] pwm_pin_out,
  output logic [NCH-1:0] pwm_pin_oe_n,
  // Interrupt
  output logic irq
);
  import tcp_pkg::*;

  logic [7:0] oe_ie_reg;
  logic [7:0] clr_ie_reg;
  logic [7:0] cks_reg;
  logic master_ie_reg;
  logic [7:0] period_reg [NCH];
  logic [7:0] duty_reg [NCH];
  logic [NCH-1:0] status_reg;
  logic [NCH-1:0] irq_en_reg;
  tcp_bus_state_t bus_reg;
  logic [1:0] rc_sync_reg;
  logic [1:0] rc2_sync_reg;
  logic rc_last_reg;
  logic rc2_last_reg;
  logic [7:0] cnt_reg [NCH];
  logic [NCH-1:0] wave_reg;
  logic [NCH-1:0] period_evt;
  logic [NCH-1:0] tick;
  logic [NCH-1:0] run;
  logic [NCH-1:0] ch_ie;
  logic rc_tick;
  logic rc2_tick;
  logic wr_oe_ie;
  logic wr_clr_ie;
  logic wr_cks;
  logic wr_master;
  logic wr_period;
  logic wr_duty;
  logic wr_irq_en;
  logic wr_stat_clr;
  logic [7:0] lane_oe_ie;
  logic [7:0] lane_clr_ie;
  logic [7:0] lane_cks;
  logic [7:0] lane_master;
  logic [7:0] lane_irq_en;
  tcp_bus_state_t bus_next;
  logic [31:0] rd_next;

  function automatic logic [1:0] cks_of(input logic [7:0] r, input int ch);
    cks_of = r[2*ch +: 2];
  endfunction

  function automatic logic [7:0] lane0(input logic [7:0] old,
                                       input tcp_av_req_t q);
    lane0 = q.byteenable[0] ? q.writedata[7:0] : old;
  endfunction

  // Strobe only on the edge the request is taken, never in the answer cycle
  function automatic logic wr_hit(input tcp_av_req_t q,
                                  input tcp_bus_state_t s,
                                  input logic [9:0] adr);
    wr_hit = q.write & (s == TCP_IDLE) & (q.address == adr);
  endfunction

  // Byte lane n carries channel n of the period and duty words
  function automatic logic [7:0] lane_n(input logic [7:0] old,
                                       input tcp_av_req_t q, input int n);
    lane_n = q.byteenable[n] ? q.writedata[8*n +: 8] : old;
  endfunction

  // Map channel interrupt enables out of their scattered bits
  always_comb begin
    ch_ie[0] = oe_ie_reg[POS_CH0_IE];
    ch_ie[1] = oe_ie_reg[POS_CH1_IE];
    ch_ie[2] = clr_ie_reg[POS_CH2_IE];
  end

  // RC clocks are asynchronous: two flops before edge detection
  always_ff @(posedge clk) begin
    if (!nrst) begin
      rc_sync_reg <= 2'h0;
      rc2_sync_reg <= 2'h0;
      rc_last_reg <= 1'b0;
      rc2_last_reg <= 1'b0;
    end else begin
      rc_sync_reg <= {rc_sync_reg[0], rc_clk_pin};
      rc2_sync_reg <= {rc2_sync_reg[0], rc2_clk_pin};
      rc_last_reg <= rc_sync_reg[1];
      rc2_last_reg <= rc2_sync_reg[1];
    end
  end

  assign rc_tick = rc_sync_reg[1] & ~rc_last_reg;
  assign rc2_tick = rc2_sync_reg[1] & ~rc2_last_reg;

  // Per-channel count source select
  always_comb begin
    for (int i = 0; i < NCH; i++) begin
      case (cks_of(cks_reg, i))
        CKS_SYS0: tick[i] = 1'b1; // [R5]
        CKS_SYS1: tick[i] = 1'b1; // [R5]
        CKS_RC: tick[i] = rc_tick; // [R5]
        CKS_RC2: tick[i] = rc2_tick; // [R5]
        default: tick[i] = 1'b1;
      endcase
      run[i] = oe_ie_reg[i] & ~clr_ie_reg[i]; // [R1] [R3]
      period_evt[i] = run[i] & tick[i] & (cnt_reg[i] == period_reg[i]);
    end
  end

  // Counters restart from zero on each wrap and while held
  always_ff @(posedge clk) begin
    if (!nrst) begin
      for (int i = 0; i < NCH; i++) begin
        cnt_reg[i] <= 8'h00;
      end
    end else begin
      for (int i = 0; i < NCH; i++) begin
        if (!run[i]) begin
          cnt_reg[i] <= 8'h00; // [R7]
        end else if (tick[i]) begin
          cnt_reg[i] <= period_evt[i] ? 8'h00 : cnt_reg[i] + 8'h01;
        end
      end
    end
  end

  // Waveform high while the count is below the duty value
  always_ff @(posedge clk) begin
    if (!nrst) begin
      wave_reg <= '0;
    end else begin
      for (int i = 0; i < NCH; i++) begin
        if (!run[i]) begin
          wave_reg[i] <= 1'b0; // [R7]
        end else if (tick[i]) begin
          wave_reg[i] <= (cnt_reg[i] < duty_reg[i]);
        end
      end
    end
  end

  // Pin level: one cycle behind the waveform
  always_ff @(posedge clk) begin
    if (!nrst) begin
      pwm_pin_out <= '0;
    end else begin
      pwm_pin_out <= wave_reg; // [R2]
    end
  end

  // Pin enable follows the enable bit only, so a held channel drives low
  always_ff @(posedge clk) begin
    if (!nrst) begin
      pwm_pin_oe_n <= '1;
    end else begin
      pwm_pin_oe_n <= ~oe_ie_reg[NCH-1:0]; // [R1] [R2]
    end
  end

  // Write decode: one strobe per register
  assign wr_oe_ie = wr_hit(av_req, bus_reg, ADR_OE_IE);
  assign wr_clr_ie = wr_hit(av_req, bus_reg, ADR_CLR_IE);
  assign wr_cks = wr_hit(av_req, bus_reg, ADR_CKS);
  assign wr_master = wr_hit(av_req, bus_reg, ADR_MASTER);
  assign wr_period = wr_hit(av_req, bus_reg, ADR_PERIOD);
  assign wr_duty = wr_hit(av_req, bus_reg, ADR_DUTY);
  assign wr_irq_en = wr_hit(av_req, bus_reg, ADR_IRQ_EN);
  assign wr_stat_clr = wr_hit(av_req, bus_reg, ADR_STAT_CLR);
  assign lane_oe_ie = lane0(oe_ie_reg, av_req);
  assign lane_clr_ie = lane0(clr_ie_reg, av_req);
  assign lane_cks = lane0(cks_reg, av_req);
  assign lane_master = lane0(8'(master_ie_reg), av_req);
  assign lane_irq_en = lane0(8'(irq_en_reg), av_req);

  // Output enables and channel 0 and 1 interrupt enables
  always_ff @(posedge clk) begin
    if (!nrst) begin
      oe_ie_reg <= RST_OE_IE;
    end else if (wr_oe_ie) begin
      oe_ie_reg <= lane_oe_ie; // [R1] [R4]
    end
  end

  // Clear-hold bits and channel 2 interrupt enable
  always_ff @(posedge clk) begin
    if (!nrst) begin
      clr_ie_reg <= RST_CLR_IE; // [R3]
    end else if (wr_clr_ie) begin
      clr_ie_reg <= lane_clr_ie; // [R3] [R4]
    end
  end

  // Clock selects; bits 7:6 are not stored and read zero
  always_ff @(posedge clk) begin
    if (!nrst) begin
      cks_reg <= RST_CKS; // [R6]
    end else if (wr_cks) begin
      cks_reg <= {2'h0, lane_cks[5:0]}; // [R6]
    end
  end

  // Shared master interrupt enable
  always_ff @(posedge clk) begin
    if (!nrst) begin
      master_ie_reg <= 1'b0;
    end else if (wr_master) begin
      master_ie_reg <= lane_master[0]; // [R4]
    end
  end

  // Status interrupt enables
  always_ff @(posedge clk) begin
    if (!nrst) begin
      irq_en_reg <= '0;
    end else if (wr_irq_en) begin
      irq_en_reg <= lane_irq_en[NCH-1:0];
    end
  end

  // Period bytes; a new value is used at the next wrap compare
  always_ff @(posedge clk) begin
    if (!nrst) begin
      for (int i = 0; i < NCH; i++) begin
        period_reg[i] <= RST_PERIOD;
      end
    end else if (wr_period) begin
      for (int i = 0; i < NCH; i++) begin
        period_reg[i] <= lane_n(period_reg[i], av_req, i);
      end
    end
  end

  // Duty bytes
  always_ff @(posedge clk) begin
    if (!nrst) begin
      for (int i = 0; i < NCH; i++) begin
        duty_reg[i] <= RST_DUTY;
      end
    end else if (wr_duty) begin
      for (int i = 0; i < NCH; i++) begin
        duty_reg[i] <= lane_n(duty_reg[i], av_req, i);
      end
    end
  end

  // Sticky period-end status; a new event wins over a clear
  always_ff @(posedge clk) begin
    if (!nrst) begin
      status_reg <= '0;
    end else begin
      for (int i = 0; i < NCH; i++) begin
        if (period_evt[i]) begin
          status_reg[i] <= 1'b1;
        end else if (wr_stat_clr && av_req.byteenable[0] &&
                     av_req.writedata[i]) begin
          status_reg[i] <= 1'b0;
        end
      end
    end
  end

  // Interrupt needs channel enable, master enable and the enable register
  always_ff @(posedge clk) begin
    if (!nrst) begin
      irq <= 1'b0;
    end else begin
      irq <= master_ie_reg & |(status_reg & irq_en_reg & ch_ie); // [R4]
    end
  end

  // Read mux; unmapped and write-only addresses read zero
  always_comb begin
    rd_next = 32'h0;
    case (av_req.address)
      ADR_OE_IE: rd_next = {24'h0, oe_ie_reg};
      ADR_CLR_IE: rd_next = {24'h0, clr_ie_reg};
      ADR_CKS: rd_next = {24'h0, cks_reg};
      ADR_MASTER: rd_next = {31'h0, master_ie_reg};
      ADR_PERIOD: rd_next = {8'h0, period_reg[2], period_reg[1],
                             period_reg[0]};
      ADR_DUTY: rd_next = {8'h0, duty_reg[2], duty_reg[1], duty_reg[0]};
      ADR_STATUS: rd_next = {29'h0, status_reg};
      ADR_IRQ_EN: rd_next = {29'h0, irq_en_reg};
      ADR_STATE: rd_next = {26'h0, wave_reg, run};
      default: rd_next = 32'h0;
    endcase
  end

  // Bus answer: waitrequest low one cycle after the request is seen
  always_comb begin
    bus_next = TCP_IDLE;
    case (bus_reg)
      TCP_IDLE: begin
        if (av_req.read || av_req.write) begin
          bus_next = TCP_ACK;
        end
      end
      TCP_ACK: bus_next = TCP_IDLE;
      default: bus_next = TCP_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      bus_reg <= TCP_IDLE;
    end else begin
      bus_reg <= bus_next;
    end
  end

  // Idle turn after each answer keeps back-to-back requests apart
  always_ff @(posedge clk) begin
    if (!nrst) begin
      av_waitrequest <= 1'b1;
    end else begin
      av_waitrequest <= (bus_next != TCP_ACK);
    end
  end

  // Read data captured with the request and held until the next one
  always_ff @(posedge clk) begin
    if (!nrst) begin
      av_readdata <= 32'h0;
    end else if (bus_next == TCP_ACK) begin
      av_readdata <= av_req.read ? rd_next : 32'h0;
    end
  end
endmodule

// ### inc/tcp_pkg.sv
// Package for the three-channel PWM control block
package tcp_pkg;
  // Register byte addresses (printed offsets are not multiples of four)
  localparam logic [7:0] IDX_OE_IE = 8'h9e;
  localparam logic [7:0] IDX_CLR_IE = 8'h9f;
  localparam logic [7:0] IDX_CKS = 8'ha1;
  localparam logic [9:0] ADR_OE_IE = {IDX_OE_IE, 2'h0};
  localparam logic [9:0] ADR_CLR_IE = {IDX_CLR_IE, 2'h0};
  localparam logic [9:0] ADR_CKS = {IDX_CKS, 2'h0};
  localparam logic [9:0] ADR_MASTER = 10'h300;
  localparam logic [9:0] ADR_PERIOD = 10'h304;
  localparam logic [9:0] ADR_DUTY = 10'h308;
  localparam logic [9:0] ADR_STATUS = 10'h30c;
  localparam logic [9:0] ADR_STAT_CLR = 10'h310;
  localparam logic [9:0] ADR_IRQ_EN = 10'h314;
  localparam logic [9:0] ADR_STATE = 10'h318;
  // Field positions
  localparam int POS_CH0_IE = 6;
  localparam int POS_CH1_IE = 7;
  localparam int POS_CH2_IE = 7;
  localparam int POS_CKS0 = 0;
  localparam int POS_CKS1 = 2;
  localparam int POS_CKS2 = 4;
  // Reset values
  localparam logic [7:0] RST_OE_IE = 8'h00;
  localparam logic [7:0] RST_CLR_IE = 8'h00;
  localparam logic [7:0] RST_CKS = 8'h2a;
  localparam logic [7:0] RST_PERIOD = 8'hff;
  localparam logic [7:0] RST_DUTY = 8'h80;
  // Clock select codes
  localparam logic [1:0] CKS_SYS0 = 2'h0;
  localparam logic [1:0] CKS_SYS1 = 2'h1;
  localparam logic [1:0] CKS_RC = 2'h2;
  localparam logic [1:0] CKS_RC2 = 2'h3;
  // Bus answer states
  typedef enum logic [1:0] {
    TCP_IDLE = 2'b00,
    TCP_ACK = 2'b01
  } tcp_bus_state_t;
  // Avalon request carrier
  typedef struct packed {
    logic [9:0] address;
    logic read;
    logic write;
    logic [3:0] byteenable;
    logic [31:0] writedata;
  } tcp_av_req_t;
endpackage

// ### sim/tcp_pin_load.sv
// Load model for the three PWM port pins
module tcp_pin_load (
  // Pins from the block
  input wire logic [2:0] pin_out,
  input wire logic [2:0] pin_oe_n,
  // Level seen by the load
  output logic [2:0] level
);
  timeunit 1ns;
  timeprecision 1ns;
  // Released pin falls to the pull-down, never keeps the last value
  always_comb level = pin_out & ~pin_oe_n;
endmodule

// ### sim/tcp_pwm_bench.sv
// Self-checking bench for the PWM control block
module tcp_pwm_bench;
  timeunit 1ns;
  timeprecision 1ns;
  import tcp_pkg::*;
  logic clk = 0;
  logic nrst = 0;
  logic rc_clk = 0;
  logic rc2_clk = 0;
  logic rc_run = 0;
  tcp_av_req_t req = '0;
  logic [31:0] av_readdata;
  logic [31:0] rdata;
  logic av_waitrequest;
  logic [2:0] pin;
  logic [2:0] oe_n;
  logic [2:0] lvl;
  logic irq;
  int err_count = 0;
  int comparisons = 0;
  int h1;
  int h2;
  int e2;
  logic last2;
  always #25 clk = ~clk;
  // RC clocks unrelated in phase to clk
  always #170 rc_clk <= rc_run ? ~rc_clk : rc_clk;
  always #85 rc2_clk <= rc_run ? ~rc2_clk : rc2_clk;
  tcp_pwm tcp_pwm_i (.clk(clk), .nrst(nrst), .rc_clk_pin(rc_clk),
    .rc2_clk_pin(rc2_clk), .av_req(req), .av_readdata(av_readdata),
    .av_waitrequest(av_waitrequest), .pwm_pin_out(pin),
    .pwm_pin_oe_n(oe_n), .irq(irq));
  tcp_pin_load tcp_pin_load_i (.pin_out(pin), .pin_oe_n(oe_n), .level(lvl));
  task automatic test_done();
    $display("comparisons %0d errors %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] exp, got);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // Holds the request until waitrequest is sampled low
  task automatic bus(input logic [9:0] a, input logic w, logic [31:0] d);
    int n = 0;
    req.address <= a;
    req.write <= w;
    req.read <= !w;
    req.writedata <= d;
    req.byteenable <= 4'hf;
    do begin
      @(posedge clk);
      n++;
    end while (av_waitrequest !== 1'b0 && n < 20);
    if (n >= 20) begin
      err_count++;
      test_done();
    end
    rdata = av_readdata;
    req.read <= 1'b0;
    req.write <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [9:0] a, input logic [31:0] d);
    bus(a, 1'b1, d);
  endtask
  task automatic rdc(input string nm, logic [9:0] a, logic [31:0] exp);
    bus(a, 1'b0, 32'h0);
    chk(nm, exp, rdata);
  endtask
  task automatic watch(input int n);
    h1 = 0;
    h2 = 0;
    e2 = 0;
    last2 = lvl[2];
    repeat (n) begin
      @(posedge clk);
      h1 += lvl[1];
      h2 += lvl[2];
      e2 += int'(lvl[2] != last2);
      last2 = lvl[2];
    end
  endtask
  initial begin
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    rdc("oe_ie", ADR_OE_IE, 32'h0);
    rdc("clr_ie", ADR_CLR_IE, 32'h0);
    rdc("cks", ADR_CKS, 32'h2a);
    rdc("unmapped", 10'h3fc, 32'h0);
    for (int c = 3; c >= 0; c--) begin
      wr(ADR_CKS, {26'h0, c[1:0], c[1:0], c[1:0]});
      rdc("cks_code", ADR_CKS, {26'h0, c[1:0], c[1:0], c[1:0]});
    end
    wr(ADR_PERIOD, 32'h030303);
    wr(ADR_DUTY, 32'h020202);
    wr(ADR_IRQ_EN, 32'h7);
    wr(ADR_OE_IE, 32'hc6);
    chk("oe_n", 32'h1, {29'h0, oe_n});
    watch(16);
    chk("p13_high", 8, h1);
    chk("p16_high", 8, h2);
    rdc("master", ADR_MASTER, 32'h0);
    chk("irq_off", 0, irq);
    wr(ADR_MASTER, 32'h1);
    chk("irq_on", 1, irq);
    wr(ADR_OE_IE, 32'h06);
    chk("irq_chan", 0, irq);
    wr(ADR_CLR_IE, 32'h80);
    chk("irq_ch2", 1, irq);
    wr(ADR_CLR_IE, 32'h86);
    watch(16);
    chk("held13", 0, h1);
    chk("held16", 0, h2);
    rdc("state", ADR_STATE, 32'h0);
    rdc("status", ADR_STATUS, 32'h6);
    wr(ADR_STAT_CLR, 32'h6);
    rdc("status_clr", ADR_STATUS, 32'h0);
    chk("irq_clr", 0, irq);
    wr(ADR_CKS, 32'h14);
    wr(ADR_CLR_IE, 32'h80);
    watch(16);
    chk("resume", 8, h1);
    wr(ADR_CKS, 32'h28);
    watch(32);
    chk("rc_still", 1, h2 == 0 || h2 == 32);
    rc_run <= 1'b1;
    watch(200);
    chk("rc_count", 1, h2 > 0 && h2 < 200);
    chk("rc_rate", 1, e2 >= 12 && e2 <= 17);
    wr(ADR_CKS, 32'h3c);
    watch(200);
    chk("rc2_count", 1, h2 > 0 && h2 < 200);
    chk("rc2_rate", 1, e2 >= 26 && e2 <= 32);
    wr(ADR_OE_IE, 32'h0);
    chk("oe_off", 32'h7, {29'h0, oe_n});
    watch(8);
    chk("off13", 0, h1);
    chk("off16", 0, h2);
    nrst <= 1'b0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    rdc("cks_rst", ADR_CKS, 32'h2a);
    rdc("clr_rst", ADR_CLR_IE, 32'h0);
    test_done();
  end
  // Limit on the whole run
  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    test_done();
  end
endmodule

// ### sim/tcp_pwm_chk.sv
// Assertion checker for the PWM control block
module tcp_pwm_chk
  import tcp_pkg::*;
#(parameter int NCH = 3) (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Register bus
  input wire tcp_pkg::tcp_av_req_t av_req,
  input wire logic [31:0] av_readdata,
  input wire logic av_waitrequest,
  // Pins and interrupt
  input wire logic [NCH-1:0] pwm_pin_out,
  input wire logic [NCH-1:0] pwm_pin_oe_n,
  input wire logic irq
);
  timeunit 1ns;
  timeprecision 1ns;
  logic mapped;
  assign mapped = av_req.address inside {ADR_OE_IE, ADR_CLR_IE, ADR_CKS,
    ADR_MASTER, ADR_PERIOD, ADR_DUTY, ADR_STATUS, ADR_STAT_CLR, ADR_IRQ_EN,
    ADR_STATE};
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  sequence s_rd(logic [9:0] a);
    av_req.read && !av_waitrequest && av_req.address == a;
  endsequence
  a_req_answered: assert property ((av_req.read || av_req.write)
    && av_waitrequest |-> ##[1:2] !av_waitrequest)
    else $error("bus request not answered in time");
  a_ack_single: assert property (!av_waitrequest |=> av_waitrequest)
    else $error("waitrequest low for more than one cycle");
  a_unmapped_zero: assert property (av_req.read && !av_waitrequest
    && !mapped |-> av_readdata == 32'h0)
    else $error("unmapped read not zero");
  a_oe_readback: assert property (
    s_rd(ADR_OE_IE) |-> av_readdata[2:0] == ~pwm_pin_oe_n)
    else $error("pin enable differs from enable bits");
  a_cks_upper_zero: assert property (
    s_rd(ADR_CKS) |-> av_readdata[31:6] == 26'h0)
    else $error("clock select upper bits not zero");
  // Undriven pin may not carry a stale waveform
  a_pin_idle_low: assert property (
    (pwm_pin_out & pwm_pin_oe_n & $past(pwm_pin_oe_n)) == '0)
    else $error("waveform on a disabled pin");
  a_irq_master_gate: assert property (
    s_rd(ADR_MASTER) ##0 !av_readdata[0] |-> !irq)
    else $error("interrupt without master enable");
  a_reset_idle: assert property ($rose(nrst) |-> av_waitrequest
    && !irq && pwm_pin_oe_n == '1 && pwm_pin_out == '0)
    else $error("outputs not idle after reset");
endmodule
bind tcp_pwm tcp_pwm_chk #(.NCH(NCH)) tcp_pwm_chk_i (.clk(clk), .nrst(nrst),
  .av_req(av_req), .av_readdata(av_readdata),
  .av_waitrequest(av_waitrequest), .pwm_pin_out(pwm_pin_out),
  .pwm_pin_oe_n(pwm_pin_oe_n), .irq(irq));
